// ===== hw/lcs_driver_end.sv
// Driver end: load-dependent fullstep commutation with step-ready handshake
// Summary of operation
// - Controller enables mode by pin or threshold
// - Microstep inputs accepted, executed as fullsteps
// - Unfinished motor step halts, ready goes low
// - Controller pauses steps while ready low
// - Buffer up to microsteps per fullstep minus one
// - Step held 1024 clocks forces one fullstep
// - Internal clock: forced pulse 125us recommended
// - Load value readable, 0 to 511
// - Load-detect threshold above minimum velocity
// - Both fast flags switch to fullstep above minimum
// - Off time 2..15, eight and above equal eight
// - Nonzero minimum velocity keeps blocked motor stepping
// - Quiet voltage chopper disables the mode
// - Reference pulse width 0..1023
// - Stall threshold 0..255
// - Stall pulses both diagnostic outputs
// - Hold input low suspends steps, ready low
`timescale 1ns/1ps
module lcs_driver_end #(
  parameter int unsigned FORCE_CYCLES = lcs_pkg::FORCE_STEP_CYCLES
) (
  input  wire logic                                  clock,
  input  wire logic                                  srst,
  lcs_link_if.drv                                    link,
  input  wire logic                                  quietChopperEnable,
  input  wire logic                                  highSpeedFsFlag,
  input  wire logic                                  highSpeedChmFlag,
  input  wire logic [lcs_pkg::OFF_TIME_WIDTH-1:0]    chopperOffTime,
  input  wire logic [lcs_pkg::VEL_WIDTH-1:0]         minCommutationVelocity,
  input  wire logic [lcs_pkg::VEL_WIDTH-1:0]         loadDetectVelocityThreshold,
  input  wire logic [lcs_pkg::VEL_WIDTH-1:0]         stepVelocity,
  input  wire logic [lcs_pkg::PULSE_WIDTH_BITS-1:0]  loadMeasurePulseWidth,
  input  wire logic [lcs_pkg::STALL_THR_WIDTH-1:0]   commutationStallThreshold,
  input  wire logic [lcs_pkg::MICROSTEP_RESOLUTION_SETTING_WIDTH-1:0]        microstepResolutionSetting,
  input  wire logic                                  motorStepDone,
  input  wire logic [lcs_pkg::LOAD_WIDTH-1:0]        loadMeasureIn,
  input  wire logic                                  minVelocityTick,
  output logic                                       modeActive,
  output logic                                       chopperFullstep,
  output logic [lcs_pkg::OFF_TIME_WIDTH-1:0]         effectiveOffTime,
  output logic                                       fullstepExec,
  output logic                                       fullstepDir,
  output logic [lcs_pkg::LOAD_WIDTH-1:0]             loadValue
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Two flops per pin since the link may come from another clock
  logic [1:0] stepSync_reg;
  logic [1:0] dirSync_reg;
  logic [1:0] enSync_reg;
  logic [1:0] holdSync_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      stepSync_reg <= 2'h0;
      dirSync_reg  <= 2'h0;
      enSync_reg   <= 2'h0;
      holdSync_reg <= 2'h3;
    end else begin
      stepSync_reg <= {stepSync_reg[0], link.stepPulse};
      dirSync_reg  <= {dirSync_reg[0], link.stepDir};
      enSync_reg   <= {enSync_reg[0], link.commutationModeEnablePin};
      holdSync_reg <= {holdSync_reg[0], link.stepHoldSyncInputN};
    end
  end

  logic stepS;
  logic stepPrev_reg;
  logic stepRise;
  logic holdActive;
  assign stepS      = stepSync_reg[1];
  assign holdActive = ~holdSync_reg[1];
  assign stepRise   = stepS & ~stepPrev_reg;

  // ****************************************
  // Mode selection and chopper settings
  // ****************************************
  // A zero minimum velocity switches the velocity-based enable off
  logic velAboveMin;
  assign velAboveMin = (minCommutationVelocity != '0) && (stepVelocity > minCommutationVelocity);

  always_comb begin
    modeActive = (enSync_reg[1] | velAboveMin) & ~quietChopperEnable;
    chopperFullstep = highSpeedFsFlag & highSpeedChmFlag & velAboveMin;
    // Values from eight upward give the same off time
    effectiveOffTime = (chopperOffTime > lcs_pkg::OFF_TIME_MAX_EFFECT) ?
                       lcs_pkg::OFF_TIME_MAX_EFFECT : chopperOffTime;
  end

  // ****************************************
  // Forced step detection
  // ****************************************
  // Counter saturates so one very long pulse forces only one fullstep
  logic [lcs_pkg::FORCE_CNT_WIDTH-1:0] forceCnt_reg;
  logic                                forceStep;

  always_ff @(posedge clock) begin
    if (srst) begin
      stepPrev_reg <= 1'b0;
      forceCnt_reg <= '0;
    end else begin
      stepPrev_reg <= stepS;
      if (!stepS)
        forceCnt_reg <= '0;
      else if (forceCnt_reg < lcs_pkg::FORCE_CNT_WIDTH'(FORCE_CYCLES))
        forceCnt_reg <= forceCnt_reg + 1'b1;
    end
  end

  // One pulse when the held step reaches the threshold
  assign forceStep = stepS &&
                     (forceCnt_reg == lcs_pkg::FORCE_CNT_WIDTH'(FORCE_CYCLES - 1));

  // ****************************************
  // Step accumulation and fullstep sequencing
  // ****************************************
  lcs_pkg::lcs_state_t state_reg;
  logic [lcs_pkg::MICROSTEP_RESOLUTION_SETTING_WIDTH-1:0] microCnt_reg;
  logic                           pendingFull;
  logic                           minTickPending_reg;

  assign pendingFull = microCnt_reg >= microstepResolutionSetting;

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg          <= lcs_pkg::LCS_IDLE;
      microCnt_reg       <= '0;
      fullstepExec       <= 1'b0;
      fullstepDir        <= 1'b0;
      minTickPending_reg <= 1'b0;
    end else begin
      fullstepExec <= 1'b0;
      if (minVelocityTick && minCommutationVelocity != '0)
        minTickPending_reg <= 1'b1;
      case (state_reg)
        lcs_pkg::LCS_IDLE: begin
          microCnt_reg <= '0;
          if (modeActive)
            state_reg <= lcs_pkg::LCS_RUN;
        end
        lcs_pkg::LCS_RUN: begin
          if (!modeActive) begin
            state_reg <= lcs_pkg::LCS_IDLE;
          end else if (holdActive) begin
            if (stepRise && microCnt_reg < microstepResolutionSetting - 1'b1)
              microCnt_reg <= microCnt_reg + 1'b1;
          end else if (pendingFull) begin
            // Execute one fullstep worth of microsteps
            fullstepExec <= 1'b1;
            fullstepDir  <= dirSync_reg[1];
            microCnt_reg <= microCnt_reg - microstepResolutionSetting + (stepRise ? 1'b1 : 1'b0);
            state_reg    <= lcs_pkg::LCS_WAIT;
          end else if (stepRise) begin
            microCnt_reg <= microCnt_reg + 1'b1;
          end
        end
        lcs_pkg::LCS_WAIT: begin
          if (!modeActive) begin
            state_reg <= lcs_pkg::LCS_IDLE;
          end else if (motorStepDone || forceStep || minTickPending_reg) begin
            // Forced or minimum-velocity restart overrides the stop
            state_reg          <= lcs_pkg::LCS_RUN;
            // A tick landing in this same cycle stays pending for the next wait
            if (!(minVelocityTick && minCommutationVelocity != '0))
              minTickPending_reg <= 1'b0;
            if (forceStep)
              microCnt_reg <= microstepResolutionSetting;
          end else if (stepRise && microCnt_reg < microstepResolutionSetting - 1'b1) begin
            // Extra steps beyond the buffer are dropped
            microCnt_reg <= microCnt_reg + 1'b1;
          end
        end
        default: state_reg <= lcs_pkg::LCS_IDLE;
      endcase
    end
  end

  // Ready combinational so the pin drops in the same cycle the stall begins
  assign link.stepReadyOutput = (state_reg == lcs_pkg::LCS_RUN) && !holdActive &&
                                modeActive;

  // ****************************************
  // Load value and stall detection
  // ****************************************
  logic [3:0] stallCnt_reg;
  logic       stallCond;
  logic       stallPrev_reg;

  // Stall: load below threshold while velocity is at or below the load-detect threshold
  // Threshold widened by one bit so loads above 255 never look stalled
  // A zero reference pulse width leaves stall detection off
  assign stallCond = modeActive && (state_reg == lcs_pkg::LCS_WAIT) &&
                     (loadMeasureIn < {1'b0, commutationStallThreshold}) &&
                     (stepVelocity <= loadDetectVelocityThreshold) &&
                     (loadMeasurePulseWidth != '0);

  always_ff @(posedge clock) begin
    if (srst) begin
      loadValue     <= '0;
      stallPrev_reg <= 1'b0;
      stallCnt_reg  <= '0;
    end else begin
      if (modeActive)
        loadValue <= loadMeasureIn;
      stallPrev_reg <= stallCond;
      if (stallCond && !stallPrev_reg)
        stallCnt_reg <= 4'(lcs_pkg::STALL_PULSE_CYCLES);
      else if (stallCnt_reg != '0)
        stallCnt_reg <= stallCnt_reg - 1'b1;
    end
  end

  assign link.faultSignalOutA = stallCnt_reg != '0;
  assign link.faultSignalOutB = stallCnt_reg != '0;

endmodule

// ===== hw/lcs_pkg.sv
// Package: constants and types shared by both ends of the step handshake
package lcs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned FORCE_STEP_CYCLES    = 1024;
  localparam int unsigned CLOCK_MHZ            = 250;
  localparam int unsigned FORCE_STEP_TIME_US   = 125;
  localparam int unsigned FORCE_STEP_INT_CYCLES = FORCE_STEP_TIME_US * CLOCK_MHZ;

  // ****************************************
  // Settings ranges and reset values
  // ****************************************
  localparam int unsigned VEL_WIDTH            = 23;
  localparam int unsigned OFF_TIME_WIDTH       = 4;
  localparam logic [3:0]  OFF_TIME_MAX_EFFECT  = 4'h8;
  localparam int unsigned PULSE_WIDTH_BITS     = 10;
  localparam int unsigned STALL_THR_WIDTH      = 8;
  localparam int unsigned LOAD_WIDTH           = 9;
  localparam int unsigned MICROSTEP_RESOLUTION_SETTING_WIDTH           = 9;
  localparam logic [8:0]  MICROSTEP_RESOLUTION_SETTING_RESET           = 9'h100;
  localparam int unsigned FORCE_CNT_WIDTH      = 11;
  localparam int unsigned STALL_PULSE_CYCLES   = 2;

  typedef enum logic [1:0] {
    LCS_IDLE,
    LCS_RUN,
    LCS_WAIT
  } lcs_state_t;

endpackage

// ===== hw/lcs_link_if.sv
// Interface: pins between the driver end and the motion controller end
`timescale 1ns/1ps
interface lcs_link_if;
  logic stepPulse;
  logic stepDir;
  logic commutationModeEnablePin;
  logic stepHoldSyncInputN;
  logic stepReadyOutput;
  logic faultSignalOutA;
  logic faultSignalOutB;

  modport drv (
    input  stepPulse,
    input  stepDir,
    input  commutationModeEnablePin,
    input  stepHoldSyncInputN,
    output stepReadyOutput,
    output faultSignalOutA,
    output faultSignalOutB
  );

  modport ctl (
    output stepPulse,
    output stepDir,
    output commutationModeEnablePin,
    output stepHoldSyncInputN,
    input  stepReadyOutput,
    input  faultSignalOutA,
    input  faultSignalOutB
  );
endinterface

// ===== hw/lcs_controller_end.sv
// Controller end: step generator that respects the step-ready handshake
`timescale 1ns/1ps
module lcs_controller_end #(
  parameter int unsigned FORCE_CYCLES = lcs_pkg::FORCE_STEP_CYCLES,
  parameter int unsigned TIMEOUT      = 4096
) (
  input  wire logic  clock,
  input  wire logic  srst,
  lcs_link_if.ctl    link,
  input  wire logic  stepReq,
  input  wire logic  stepReqDir,
  input  wire logic  modeEnableReq,
  input  wire logic  syncHoldReq,
  input  wire logic  forceAllowed,
  output logic       stepAccept,
  output logic       stallSeen
);

  logic [1:0]  readySync_reg;
  logic [1:0]  faultSync_reg;
  logic [15:0] waitCnt_reg;
  logic [15:0] pulseCnt_reg;
  logic        forcing_reg;
  logic        ready;

  always_ff @(posedge clock) begin
    if (srst) begin
      readySync_reg <= 2'h0;
      faultSync_reg <= 2'h0;
    end else begin
      readySync_reg <= {readySync_reg[0], link.stepReadyOutput};
      faultSync_reg <= {faultSync_reg[0], link.faultSignalOutA | link.faultSignalOutB};
    end
  end
  assign ready = readySync_reg[1];

  // Accept steps only while ready and not forcing
  assign stepAccept = ready && !forcing_reg && (pulseCnt_reg == '0);

  always_ff @(posedge clock) begin
    if (srst) begin
      link.stepPulse                <= 1'b0;
      link.stepDir                  <= 1'b0;
      link.commutationModeEnablePin <= 1'b0;
      link.stepHoldSyncInputN       <= 1'b1;
      waitCnt_reg                   <= '0;
      pulseCnt_reg                  <= '0;
      forcing_reg                   <= 1'b0;
      stallSeen                     <= 1'b0;
    end else begin
      link.commutationModeEnablePin <= modeEnableReq;
      link.stepHoldSyncInputN       <= ~syncHoldReq;
      if (faultSync_reg[1])
        stallSeen <= 1'b1;
      waitCnt_reg <= ready ? '0 : waitCnt_reg + ((waitCnt_reg != 16'hffff) ? 1'b1 : 1'b0);
      if (pulseCnt_reg != '0) begin
        pulseCnt_reg <= pulseCnt_reg - 1'b1;
        if (pulseCnt_reg == 16'h0001) begin
          link.stepPulse <= 1'b0;
          forcing_reg    <= 1'b0;
        end
      end else if (stepReq && stepAccept) begin
        link.stepPulse <= 1'b1;
        link.stepDir   <= stepReqDir;
        pulseCnt_reg   <= 16'h0002;
      end else if (!ready && forceAllowed && waitCnt_reg >= 16'(TIMEOUT)) begin
        // Margin above the minimum so sync delay cannot shorten it
        link.stepPulse <= 1'b1;
        forcing_reg    <= 1'b1;
        pulseCnt_reg   <= 16'(FORCE_CYCLES + 8);
        waitCnt_reg    <= '0;
      end
    end
  end

endmodule

// ===== sim/lcs_link_assertions.sv
// Checker: timing relations on the step handshake pins
`timescale 1ns/1ps
module lcs_link_assertions #(
  parameter int unsigned FORCE_CYCLES = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic stepPulse,
  input wire logic stepDir,
  input wire logic commutationModeEnablePin,
  input wire logic stepHoldSyncInputN,
  input wire logic stepReadyOutput,
  input wire logic faultSignalOutA,
  input wire logic faultSignalOutB
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // ****************************************
  // Helper counter of step high time
  // ****************************************
  logic [15:0] highCnt_reg;
  always_ff @(posedge clock) begin
    if (srst) highCnt_reg <= 16'h0000;
    else if (stepPulse) highCnt_reg <= highCnt_reg + 16'h0001;
    else highCnt_reg <= 16'h0000;
  end
  // ****************************************
  // Properties
  // ****************************************
  property p_hold_forces_low;
    (!stepHoldSyncInputN) [*4] |-> !stepReadyOutput;
  endproperty
  a_hold_forces_low: assert property (p_hold_forces_low)
    else $error("ready high while hold input low");
  // Controller sees ready through two flops, so a rise answers the level three cycles back
  property p_no_step_while_waiting;
    commutationModeEnablePin && $rose(stepPulse) && !$past(stepReadyOutput, 3) |-> stepPulse [*8];
  endproperty
  a_no_step_while_waiting: assert property (p_no_step_while_waiting)
    else $error("short step issued while ready low");
  property p_pulse_length;
    $fell(stepPulse) |-> (highCnt_reg == 16'h0002) || (highCnt_reg >= FORCE_CYCLES);
  endproperty
  a_pulse_length: assert property (p_pulse_length)
    else $error("step pulse length neither normal nor forced");
  property p_pulse_two_high;
    $rose(stepPulse) |=> stepPulse;
  endproperty
  a_pulse_two_high: assert property (p_pulse_two_high)
    else $error("step pulse shorter than two cycles");
  // Two high and one low give at least three cycles between rises
  property p_pulse_gap;
    $rose(stepPulse) |=> !$rose(stepPulse) ##1 !$rose(stepPulse);
  endproperty
  a_pulse_gap: assert property (p_pulse_gap)
    else $error("step pulses spaced too close");
  property p_fault_a_pulse;
    $rose(faultSignalOutA) |=> faultSignalOutA ##1 !faultSignalOutA;
  endproperty
  a_fault_a_pulse: assert property (p_fault_a_pulse)
    else $error("fault output a pulse not two cycles");
  property p_fault_b_pulse;
    $rose(faultSignalOutB) |=> faultSignalOutB ##1 !faultSignalOutB;
  endproperty
  a_fault_b_pulse: assert property (p_fault_b_pulse)
    else $error("fault output b pulse not two cycles");
  property p_dir_stable;
    stepPulse && $past(stepPulse) |-> $stable(stepDir);
  endproperty
  a_dir_stable: assert property (p_dir_stable)
    else $error("direction changed during step pulse");
  c_fault: cover property ($rose(faultSignalOutA));
  c_forced: cover property ($fell(stepPulse) && highCnt_reg >= FORCE_CYCLES);
  c_hold: cover property (!stepHoldSyncInputN && !stepReadyOutput);
endmodule

// ===== sim/test_load_commutation_step_handshake.sv
// Testbench: both ends joined, user sides driven and observed
`timescale 1ns/1ps
module test_load_commutation_step_handshake;
  typedef struct {
    logic q; logic fs; logic chm; logic [3:0] off; logic [22:0] vel; logic [22:0] mv;
    logic expMode; logic expFs; logic [3:0] expOff;
  } lcs_row_t;
  localparam int unsigned FC = 16;
  logic clock = 1'b0, srst = 1'b1, quiet = 1'b0, fs = 1'b0, chm = 1'b0, stepDone = 1'b0;
  logic tick = 1'b0, stepReq = 1'b0, stepReqDir = 1'b0, modeReq = 1'b0, holdReq = 1'b0;
  logic forceOk = 1'b0;
  logic [3:0] offT = 4'h0;
  logic [22:0] minVel = 23'h0, ldThr = 23'h0, vel = 23'h0;
  logic [9:0] pw = 10'h000;
  logic [7:0] sgThr = 8'h00;
  logic [8:0] microstep_resolution_setting = 9'h004, load = 9'h000;
  logic modeAct, chopFs, exec, execDir, stepAccept, stallSeen;
  logic [3:0] effOff;
  logic [8:0] loadVal;
  int numErrors = 0, nTests = 0, cycles = 0, execCnt = 0, i;
  lcs_row_t rows [5] = '{
    '{1'b0, 1'b1, 1'b1, 4'h3, 23'h000200, 23'h000100, 1'b1, 1'b1, 4'h3},
    '{1'b0, 1'b1, 1'b0, 4'hf, 23'h000200, 23'h000100, 1'b1, 1'b0, 4'h8},
    '{1'b0, 1'b0, 1'b1, 4'h8, 23'h000200, 23'h000100, 1'b1, 1'b0, 4'h8},
    '{1'b0, 1'b1, 1'b1, 4'h2, 23'h000100, 23'h000100, 1'b1, 1'b0, 4'h2},
    '{1'b1, 1'b0, 1'b0, 4'h9, 23'h000200, 23'h000100, 1'b0, 1'b0, 4'h8}};
  always #2 clock = ~clock;
  lcs_link_if u_lcs_link_if ();
  lcs_driver_end #(.FORCE_CYCLES(FC)) u_lcs_driver_end (.clock(clock), .srst(srst),
    .link(u_lcs_link_if.drv), .quietChopperEnable(quiet), .highSpeedFsFlag(fs),
    .highSpeedChmFlag(chm), .chopperOffTime(offT), .minCommutationVelocity(minVel),
    .loadDetectVelocityThreshold(ldThr), .stepVelocity(vel), .loadMeasurePulseWidth(pw),
    .commutationStallThreshold(sgThr), .microstepResolutionSetting(microstep_resolution_setting),
    .motorStepDone(stepDone), .loadMeasureIn(load), .minVelocityTick(tick),
    .modeActive(modeAct), .chopperFullstep(chopFs), .effectiveOffTime(effOff),
    .fullstepExec(exec), .fullstepDir(execDir), .loadValue(loadVal));
  lcs_controller_end #(.FORCE_CYCLES(FC), .TIMEOUT(32)) u_lcs_controller_end (.clock(clock),
    .srst(srst), .link(u_lcs_link_if.ctl), .stepReq(stepReq), .stepReqDir(stepReqDir),
    .modeEnableReq(modeReq), .syncHoldReq(holdReq), .forceAllowed(forceOk),
    .stepAccept(stepAccept), .stallSeen(stallSeen));
  lcs_link_assertions #(.FORCE_CYCLES(FC)) u_lcs_link_assertions (.clock(clock), .srst(srst),
    .stepPulse(u_lcs_link_if.stepPulse), .stepDir(u_lcs_link_if.stepDir),
    .commutationModeEnablePin(u_lcs_link_if.commutationModeEnablePin),
    .stepHoldSyncInputN(u_lcs_link_if.stepHoldSyncInputN),
    .stepReadyOutput(u_lcs_link_if.stepReadyOutput),
    .faultSignalOutA(u_lcs_link_if.faultSignalOutA),
    .faultSignalOutB(u_lcs_link_if.faultSignalOutB));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string name, input logic [22:0] exp, input logic [22:0] got);
    nTests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      numErrors++;
    end
  endtask
  task automatic endOfTest();
    if (numErrors == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (exec === 1'b1) execCnt++;
    if (cycles == 5000) begin
      numErrors++;
      endOfTest();
    end
  end
  initial begin
    cyc(9);
    chk("ready in reset", 23'h0, {22'h0, u_lcs_link_if.stepReadyOutput});
    chk("faults in reset", 23'h0,
        {21'h0, u_lcs_link_if.faultSignalOutA, u_lcs_link_if.faultSignalOutB});
    cyc(1);
    srst = 1'b0;
    pw = 10'h040; sgThr = 8'h0a; ldThr = 23'h7fffff; load = 9'h1f5; modeReq = 1'b1;
    for (i = 0; i < 5; i++) begin
      quiet = rows[i].q; fs = rows[i].fs; chm = rows[i].chm; offT = rows[i].off;
      vel = rows[i].vel; minVel = rows[i].mv;
      cyc(5);
      chk("modeActive", {22'h0, rows[i].expMode}, {22'h0, modeAct});
      chk("chopperFullstep", {22'h0, rows[i].expFs}, {22'h0, chopFs});
      chk("effectiveOffTime", {19'h0, rows[i].expOff}, {19'h0, effOff});
    end
    quiet = 1'b0; fs = 1'b1; chm = 1'b1; offT = 4'h4; vel = 23'h000200;
    cyc(5);
    chk("loadValue", 23'h0001f5, {14'h0, loadVal});
    // ****************************************
    // Handshake stall, refusal, forced step, hold
    // ****************************************
    // Zero load below the stall threshold so the wait also raises a stall pulse
    load = 9'h000; stepReqDir = 1'b1; stepReq = 1'b1;
    for (i = 0; i < 200 && execCnt < 1; i++) cyc(1);
    cyc(2);
    chk("execCnt one", 23'h1, execCnt[22:0]);
    chk("ready waiting", 23'h0, {22'h0, u_lcs_link_if.stepReadyOutput});
    chk("fullstepDir", 23'h1, {22'h0, execDir});
    chk("stepAccept waiting", 23'h0, {22'h0, stepAccept});
    cyc(60);
    chk("execCnt held", 23'h1, execCnt[22:0]);
    chk("stallSeen", 23'h1, {22'h0, stallSeen});
    forceOk = 1'b1;
    for (i = 0; i < 400 && execCnt < 2; i++) cyc(1);
    chk("execCnt forced", 23'h2, execCnt[22:0]);
    forceOk = 1'b0; stepReq = 1'b0; stepDone = 1'b1;
    cyc(6);
    chk("ready done", 23'h1, {22'h0, u_lcs_link_if.stepReadyOutput});
    holdReq = 1'b1;
    cyc(6);
    chk("ready hold", 23'h0, {22'h0, u_lcs_link_if.stepReadyOutput});
    holdReq = 1'b0;
    cyc(6);
    chk("ready release", 23'h1, {22'h0, u_lcs_link_if.stepReadyOutput});
    chk("stepAccept release", 23'h1, {22'h0, stepAccept});
    // Blocked motor: only the minimum-velocity tick may end the wait
    stepDone = 1'b0; stepReq = 1'b1;
    for (i = 0; i < 200 && execCnt < 3; i++) cyc(1);
    stepReq = 1'b0;
    cyc(20);
    chk("ready blocked", 23'h0, {22'h0, u_lcs_link_if.stepReadyOutput});
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(3);
    chk("ready after tick", 23'h1, {22'h0, u_lcs_link_if.stepReadyOutput});
    // Reset again in mid-run
    srst = 1'b1;
    cyc(2);
    chk("ready mid reset", 23'h0, {22'h0, u_lcs_link_if.stepReadyOutput});
    chk("stallSeen mid reset", 23'h0, {22'h0, stallSeen});
    srst = 1'b0;
    cyc(6);
    chk("ready after reset", 23'h1, {22'h0, u_lcs_link_if.stepReadyOutput});
    chk("exec after reset", 23'h0, {22'h0, exec});
    endOfTest();
  end
endmodule
